// ### speaker_output_diagnostic_sequencer.sv
// turn-on, permanent and offset diagnostic sequencing for four bridge channels
`timescale 1ns/1ps
`include "spk_diag_map.svh"
module speaker_output_diagnostic_sequencer #(
    parameter int unsigned CHECK_CYCLES = `CHECK_CYCLES
) (
    // clock, reset and clock enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // instruction bits and read strobe from the bus slave
    input wire spk_diag_pkg::ctrl_t ctrl,
    input wire logic host_read,
    // analog comparators, asynchronous
    input wire spk_diag_pkg::sense_t [3:0] sense,
    // amplifier control and results
    output spk_diag_pkg::status_t status,
    output spk_diag_pkg::result_t [3:0] report
);
    localparam logic [6:0] DIAG_LAST = 7'(`DIAG_TICKS - 1);
    localparam logic [31:0] TICK_LAST = 32'(CHECK_CYCLES - 1);
    localparam logic [3:0] FRONT = `FRONT_MASK;

    spk_diag_pkg::state_t st;
    spk_diag_pkg::state_t next_st;

    // any output short seen by a channel
    function automatic logic any_short(input spk_diag_pkg::sense_t s);
        any_short = s.short_gnd | s.short_vs | s.short_load;
    endfunction : any_short

    // result word from sampled comparators
    function automatic spk_diag_pkg::result_t capture(input spk_diag_pkg::sense_t s,
                                                       input logic perm,
                                                       input logic keep_off);
        capture = '0;
        capture.permanent = perm;
        capture.short_gnd = s.short_gnd;
        capture.short_vs = s.short_vs;
        capture.short_load = s.short_load;
        capture.open_load = perm ? 1'b0 : s.open_load;
        capture.double_fault = perm ? 1'b0 : s.open_load & (s.short_gnd | s.short_vs); // see R20
        capture.offset = keep_off;
    endfunction : capture

    // next-state logic
    always_comb begin
        next_st = st;
        // comparators cross in through two flops
        next_st.sync1 = sense;
        next_st.sync2 = st.sync1;
        // one shared 1 ms tick feeds every timer
        next_st.tick = 1'b0;
        if (st.prescale == TICK_LAST) begin
            next_st.prescale = '0;
            next_st.tick = 1'b1; // see R24
        end else begin
            next_st.prescale = st.prescale + 32'h00000001;
        end
        // threshold set follows gain and line-driver setting
        for (int c = 0; c < 4; c++) begin
            next_st.out.line_mode[c] = ctrl.line_driver_diag &
                (FRONT[c] ? ctrl.voltage_gain_setting[1] : ctrl.voltage_gain_setting[0]); // see R06
        end
        next_st.out.offset_active = ctrl.offset_enable_bit & (st.seq == spk_diag_pkg::SEQ_PLAY);

        // power-up sequence
        case (st.seq)
            spk_diag_pkg::SEQ_STANDBY: begin
                next_st.out.hiz = 1'b1;
                next_st.out.biased = 1'b0;
                next_st.out.pulse = 1'b0;
                next_st.out.channel_on = '0;
                if (ctrl.standby_off) begin
                    if (ctrl.diag_enable_bit && st.armed) begin
                        // test pulse runs before bias, outputs floating
                        next_st.seq = spk_diag_pkg::SEQ_PULSE; // see R01 R03
                        next_st.seq_ticks = '0;
                        next_st.out.pulse = 1'b1;
                        next_st.out.cycle_done = 1'b0;
                    end else begin
                        next_st.seq = spk_diag_pkg::SEQ_PLAY;
                        next_st.out.hiz = 1'b0;
                        next_st.out.biased = 1'b1;
                        next_st.out.channel_on = 4'hf;
                        next_st.ch = {4{spk_diag_pkg::CH_ACTIVE}};
                    end
                end
            end
            spk_diag_pkg::SEQ_PULSE: begin
                if (!ctrl.standby_off || !ctrl.diag_enable_bit) begin // see R22
                    // aborted pulse leaves stored results alone
                    next_st.seq = spk_diag_pkg::SEQ_STANDBY; // see R25
                    next_st.out.pulse = 1'b0;
                end else if (st.tick) begin
                    next_st.seq_ticks = st.seq_ticks + 7'h01;
                    if (st.seq_ticks == DIAG_LAST) begin
                        // latch at end of pulse top, then bias the stage
                        for (int c = 0; c < 4; c++) begin
                            next_st.live[c] = capture(st.sync2[c], 1'b0, st.live[c].offset); // see R05
                        end
                        next_st.armed = 1'b0; // see R02
                        next_st.out.cycle_done = 1'b1; // see R23
                        next_st.out.pulse = 1'b0;
                        next_st.out.hiz = 1'b0;
                        next_st.out.biased = 1'b1; // see R03
                        next_st.out.channel_on = 4'hf;
                        next_st.ch = {4{spk_diag_pkg::CH_ACTIVE}};
                        next_st.seq = spk_diag_pkg::SEQ_PLAY;
                    end
                end
            end
            spk_diag_pkg::SEQ_PLAY: begin
                if (!ctrl.standby_off) begin
                    next_st.seq = spk_diag_pkg::SEQ_STANDBY;
                    next_st.ch = {4{spk_diag_pkg::CH_RESTART}}; // see R25
                    next_st.out.channel_on = '0;
                    next_st.out.biased = 1'b0;
                    next_st.out.hiz = 1'b1;
                end else begin
                    // every channel handled on its own
                    for (int c = 0; c < 4; c++) begin
                        case (st.ch[c])
                            spk_diag_pkg::CH_ACTIVE: begin
                                if (st.sync2[c].overload) begin
                                    next_st.out.channel_on[c] = 1'b0;
                                    next_st.ticks[c] = '0;
                                    if (ctrl.diag_enable_bit && st.armed) begin
                                        next_st.ch[c] = spk_diag_pkg::CH_CHECK; // see R09
                                    end else begin
                                        next_st.ch[c] = spk_diag_pkg::CH_RESTART; // see R08
                                    end
                                end
                            end
                            spk_diag_pkg::CH_RESTART: begin
                                // sampled on the tick grid only
                                if (st.tick && !st.sync2[c].overload) begin
                                    next_st.ch[c] = spk_diag_pkg::CH_ACTIVE; // see R08
                                    next_st.out.channel_on[c] = 1'b1;
                                end
                            end
                            spk_diag_pkg::CH_CHECK: begin
                                if (!ctrl.diag_enable_bit) begin
                                    next_st.ch[c] = spk_diag_pkg::CH_RESTART; // see R25
                                end else if (st.tick) begin
                                    if (!st.sync2[c].overload) begin
                                        // recirculation spike only, no cycle
                                        next_st.ch[c] = spk_diag_pkg::CH_ACTIVE; // see R10
                                        next_st.out.channel_on[c] = 1'b1;
                                    end else begin
                                        next_st.ch[c] = spk_diag_pkg::CH_DIAG; // see R11
                                        next_st.ticks[c] = '0;
                                        next_st.out.cycle_done = 1'b0;
                                    end
                                end
                            end
                            spk_diag_pkg::CH_DIAG: begin
                                if (!ctrl.diag_enable_bit) begin
                                    next_st.ch[c] = spk_diag_pkg::CH_RESTART; // see R25
                                end else if (st.tick) begin
                                    next_st.ticks[c] = st.ticks[c] + 7'h01;
                                    if (st.ticks[c] == DIAG_LAST) begin
                                        // turn-on data stays unless a short is found
                                        if (any_short(st.sync2[c])) begin
                                            next_st.live[c] = capture(st.sync2[c], 1'b1,
                                                                      st.live[c].offset); // see R04 R07
                                        end
                                        next_st.ch[c] = spk_diag_pkg::CH_RESTART; // see R12
                                        next_st.armed = 1'b0; // see R13
                                    end
                                end
                            end
                            default: begin
                                next_st.ch[c] = spk_diag_pkg::CH_RESTART;
                            end
                        endcase
                    end
                    // completion flag set last so it beats the clear of a new start
                    for (int c = 0; c < 4; c++) begin
                        if (st.ch[c] == spk_diag_pkg::CH_DIAG && ctrl.diag_enable_bit &&
                            st.tick && st.ticks[c] == DIAG_LAST) begin
                            next_st.out.cycle_done = 1'b1; // see R23
                        end
                    end
                end
            end
            default: begin
                next_st.seq = spk_diag_pkg::SEQ_STANDBY;
            end
        endcase

        // offset window accumulates persistence and suppression
        next_st.off_en_q = ctrl.offset_enable_bit;
        for (int c = 0; c < 4; c++) begin
            if (!st.sync2[c].offset_high) begin
                next_st.win_ok[c] = 1'b0; // see R17
            end
            if (st.sync2[c].overload) begin
                next_st.win_sup[c] = 1'b1; // see R18
            end
        end

        // a read shows what was stored before it, then re-arms
        if (host_read) begin
            next_st.report = st.live; // see R21 R19
            if (st.win_open && ctrl.offset_enable_bit) begin
                for (int c = 0; c < 4; c++) begin
                    next_st.live[c].offset = st.win_ok[c] & st.sync2[c].offset_high &
                                             ~st.win_sup[c]; // see R15 R16
                end
            end
            next_st.armed = 1'b1; // see R13
        end
        // window restarts at each read or at offset enable
        if (host_read || (ctrl.offset_enable_bit && !st.off_en_q)) begin
            next_st.win_ok = 4'hf; // see R16
            next_st.win_sup = '0;
            next_st.win_open = ctrl.offset_enable_bit;
        end
        if (!ctrl.offset_enable_bit) begin
            next_st.win_open = 1'b0;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.seq <= spk_diag_pkg::SEQ_STANDBY;
            st.ch <= {4{spk_diag_pkg::CH_RESTART}};
            st.armed <= `ARMED_RESET;
            st.out.hiz <= `HIZ_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign status = st.out;
    assign report = st.report;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_spike_recover: assert property ( // see R10
        ce && st.seq == spk_diag_pkg::SEQ_PLAY && ctrl.standby_off && ctrl.diag_enable_bit &&
        st.ch[0] == spk_diag_pkg::CH_CHECK && st.tick && !st.sync2[0].overload
        |=> st.ch[0] == spk_diag_pkg::CH_ACTIVE && st.out.channel_on[0])
        else $error("check without overload did not reactivate channel");
    chk_check_to_cycle: assert property ( // see R11
        ce && st.seq == spk_diag_pkg::SEQ_PLAY && ctrl.standby_off && ctrl.diag_enable_bit &&
        st.ch[1] == spk_diag_pkg::CH_CHECK && st.tick && st.sync2[1].overload
        |=> st.ch[1] == spk_diag_pkg::CH_DIAG && st.ticks[1] == 7'h00 && !st.out.channel_on[1])
        else $error("persisting overload did not start diagnostic cycle");
    chk_plain_restart: assert property ( // see R08
        ce && st.seq == spk_diag_pkg::SEQ_PLAY && ctrl.standby_off && !ctrl.diag_enable_bit &&
        st.ch[2] == spk_diag_pkg::CH_ACTIVE && st.sync2[2].overload
        |=> st.ch[2] == spk_diag_pkg::CH_RESTART && !st.out.channel_on[2])
        else $error("overload without diagnostics did not shut channel");
    chk_pulse_float: assert property ( // see R03
        st.seq == spk_diag_pkg::SEQ_PULSE |-> st.out.hiz && !st.out.biased && st.out.pulse)
        else $error("test pulse with outputs not floating");
    chk_read_prior: assert property ( // see R21
        ce && host_read |=> st.report == $past(st.live))
        else $error("read did not present previously stored results");
    chk_pulse_done: assert property ( // see R23
        ce && st.seq == spk_diag_pkg::SEQ_PULSE && ctrl.standby_off && ctrl.diag_enable_bit &&
        st.tick && st.seq_ticks == DIAG_LAST && !host_read
        |=> st.out.cycle_done && st.seq == spk_diag_pkg::SEQ_PLAY && !st.armed)
        else $error("turn-on cycle end not flagged");
    chk_line_select: assert property ( // see R06
        ce |=> st.out.line_mode[0] == $past(ctrl.line_driver_diag && ctrl.voltage_gain_setting[1])
        && st.out.line_mode[1] == $past(ctrl.line_driver_diag && ctrl.voltage_gain_setting[0]))
        else $error("line-driver threshold select wrong");
    chk_standby_abort: assert property ( // see R25
        ce && st.seq == spk_diag_pkg::SEQ_PLAY && !ctrl.standby_off
        |=> st.seq == spk_diag_pkg::SEQ_STANDBY && st.ch == {4{spk_diag_pkg::CH_RESTART}}
        && st.live == $past(st.live))
        else $error("stand-by did not abort to restart mode");
    chk_read_rearm: assert property ( // see R13
        ce && host_read |=> st.armed)
        else $error("read did not re-arm diagnostics");
    chk_tick_period: assert property ( // see R24
        ce && st.tick |=> !st.tick)
        else $error("time base tick longer than one cycle");
endmodule : speaker_output_diagnostic_sequencer

// ### spk_diag_map.svh
// timing counts, channel layout and reset values for the speaker diagnostic sequencer
// Function
// R01 - on stand-by exit with diagnostics on, run turn-on test for all four faults
// R02 - hold turn-on result until a host read re-arms a new test pulse
// R03 - combined stand-by exit and enable: pulse with outputs hi-z, then bias
// R04 - keep reporting turn-on result until a short shows up on an output
// R05 - latch output status at end of the 100 ms test pulse top
// R06 - line-driver thresholds only with 12 dB gain and line-driver setting
// R07 - in play detect ground, supply and load shorts plus output offset
// R08 - diagnostics off: shut faulty channel, recheck each 1 ms, restart when clear
// R09 - diagnostics on: overload tripping protection starts the diagnostic procedure
// R10 - check output 1 ms after trip; if clear, skip diagnostic and reactivate
// R11 - overload still present at the check: run a 100 ms diagnostic cycle
// R12 - at cycle end put channel in restart mode and store fault data
// R13 - next diagnostic cycle starts only after a host read
// R14 - host polls status at its own interval, over half a second advised
// R15 - flag output DC offset beyond about 2 V of either polarity
// R16 - offset window opens at previous read or offset enable, ends at read
// R17 - report offset only if it held through the whole window
// R18 - overload tripping protection during the window suppresses the offset result
// R19 - with several faults report at least one, the rest on later cycles
// R20 - a short with the speaker unconnected is reported as a double fault
// R21 - a read returns the previous cycle's data; two reads show a change
// R22 - diagnostic enable bit high enables diagnostics, low disables them
// R23 - cycle-terminated flag is high only after a diagnostic cycle ends
// R24 - 1 ms check tick and 100 ms cycle come from one shared time base
// R25 - stand-by or disable aborts cycles, channels to restart, results kept
`ifndef SPK_DIAG_MAP_SVH
`define SPK_DIAG_MAP_SVH
`define CLOCK_KHZ 250000
`define CHECK_TIME_MS 1
`define CHECK_CYCLES (`CHECK_TIME_MS * `CLOCK_KHZ)
`define DIAG_TIME_MS 100
`define DIAG_TICKS (`DIAG_TIME_MS / `CHECK_TIME_MS)
`define FRONT_MASK 4'h5
`define ARMED_RESET 1'b1
`define HIZ_RESET 1'b1
`endif

// ### spk_diag_pkg.sv
// types shared by the speaker diagnostic sequencer
package spk_diag_pkg;
    // per-channel handling while the amplifier plays
    typedef enum logic [3:0] {
        CH_ACTIVE = 4'h1,
        CH_CHECK = 4'h2,
        CH_DIAG = 4'h4,
        CH_RESTART = 4'h8
    } ch_state_t;
    // power-up sequence of the whole amplifier
    typedef enum logic [2:0] {
        SEQ_STANDBY = 3'h1,
        SEQ_PULSE = 3'h2,
        SEQ_PLAY = 3'h4
    } seq_state_t;
    // analog comparator outputs of one channel
    typedef struct packed {
        logic overload;
        logic short_gnd;
        logic short_vs;
        logic short_load;
        logic open_load;
        logic offset_high;
    } sense_t;
    // instruction bits as held by the bus slave; gain bit 1 front, bit 0 rear
    typedef struct packed {
        logic standby_off;
        logic diag_enable_bit;
        logic offset_enable_bit;
        logic line_driver_diag;
        logic [1:0] voltage_gain_setting;
    } ctrl_t;
    // stored result of one channel
    typedef struct packed {
        logic permanent;
        logic double_fault;
        logic short_load;
        logic open_load;
        logic offset;
        logic short_vs;
        logic short_gnd;
    } result_t;
    // amplifier control and status levels
    typedef struct packed {
        logic pulse;
        logic hiz;
        logic biased;
        logic cycle_done;
        logic offset_active;
        logic [3:0] channel_on;
        logic [3:0] line_mode;
    } status_t;
    // whole state of the sequencer
    typedef struct packed {
        seq_state_t seq;
        ch_state_t [3:0] ch;
        logic [3:0][6:0] ticks;
        logic [6:0] seq_ticks;
        logic [31:0] prescale;
        logic tick;
        sense_t [3:0] sync1;
        sense_t [3:0] sync2;
        result_t [3:0] live;
        result_t [3:0] report;
        logic armed;
        logic off_en_q;
        logic win_open;
        logic [3:0] win_ok;
        logic [3:0] win_sup;
        status_t out;
    } state_t;
endpackage : spk_diag_pkg

// ### spk_host_model.sv
// host controller model: writes instruction bits and issues diagnostic reads
`timescale 1ns/1ps
module spk_host_model (
    // clock
    input wire logic clock,
    // toward the sequencer
    output spk_diag_pkg::ctrl_t ctrl,
    output logic host_read
);
    // quiet host at time zero
    initial begin
        ctrl = '0;
        host_read = 1'b0;
    end

    // new instruction bits just after an edge, held until rewritten
    task automatic write_ctrl(input spk_diag_pkg::ctrl_t value);
        @(posedge clock);
        ctrl <= value;
    endtask : write_ctrl

    // one completed read; the poll interval is the caller's choice
    task automatic read_once();
        @(posedge clock);
        host_read <= 1'b1;
        @(posedge clock);
        host_read <= 1'b0;
    endtask : read_once
endmodule : spk_host_model

// ### tb_top.sv
// self-checking bench for the speaker diagnostic sequencer
`timescale 1ns/1ps
module tb_top;
    // short tick keeps a 100 tick cycle near 1000 clocks
    localparam int TICK = 10;
    localparam int CYC = 100 * TICK;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    spk_diag_pkg::sense_t [3:0] sense = '0;
    spk_diag_pkg::ctrl_t ctrl;
    logic host_read;
    spk_diag_pkg::status_t status;
    spk_diag_pkg::result_t [3:0] report;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int took;

    // 250 MHz clock
    always #2 clock = ~clock;

    spk_host_model host (
        .clock(clock),
        .ctrl(ctrl),
        .host_read(host_read)
    );

    speaker_output_diagnostic_sequencer #(.CHECK_CYCLES(TICK)) dut (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .ctrl(ctrl),
        .host_read(host_read),
        .sense(sense),
        .status(status),
        .report(report)
    );

    // verdict and end of run
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // hang guard, a few times the expected run length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // watched bit: 0..3 channel enable, 4 cycle done, 5 test pulse
    function automatic logic pick(input int sel);
        return sel < 4 ? status.channel_on[sel] : (sel == 4 ? status.cycle_done : status.pulse);
    endfunction : pick

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // bounded wait; took keeps the cycles spent for timing checks
    task automatic wait_bit(input int sel, input logic val, input int limit);
        took = 0;
        while (pick(sel) !== val && took < limit) begin
            step(1);
            took++;
        end
        check(pick(sel), val, "wait");
    endtask : wait_bit

    // reset with sense levels in place, then write the instruction bits
    task automatic start(input spk_diag_pkg::ctrl_t c, input spk_diag_pkg::sense_t [3:0] s);
        rst <= 1'b1;
        sense <= s;
        host.write_ctrl('0);
        step(3);
        check(status, 32'h800, "reset status");
        check(report, 32'h0, "reset report");
        rst <= 1'b0;
        host.write_ctrl(c);
        step(1);
    endtask : start

    // ctrl codes: 30 stand-by out with diag, 36 adds line driver and front 12 dB
    task automatic scn_turn_on();
        spk_diag_pkg::sense_t [3:0] s;
        s = '0;
        s[0].short_gnd = 1'b1;
        s[1].open_load = 1'b1;
        s[1].short_gnd = 1'b1;
        s[2].short_load = 1'b1;
        s[3].short_vs = 1'b1;
        start(6'h36, s);
        check({status.pulse, status.hiz, status.channel_on}, 6'h30, "pulse hi-z");
        check(status.cycle_done, 1'b0, "done early");
        wait_bit(5, 1'b0, CYC + 3 * TICK);
        check(took > CYC - 3 * TICK, 1'b1, "acquisition");
        check({status.biased, status.hiz, status.channel_on}, 6'h2f, "biased");
        check(status.cycle_done, 1'b1, "done");
        check(status.line_mode, 4'h5, "line mode");
        check(report, 32'h0, "early read");
        sense <= '0;
        host.read_once();
        step(1);
        check(report[0].short_gnd, 1'b1, "gnd");
        check(report[1].double_fault, 1'b1, "double");
        check(report[2].short_load, 1'b1, "load");
        check(report[3].short_vs, 1'b1, "vs");
        check(report[0].permanent, 1'b0, "kind");
        step(50);
        host.read_once();
        step(1);
        check(report[2].short_load, 1'b1, "held");
    endtask : scn_turn_on

    task automatic scn_permanent();
        start(6'h30, '0);
        wait_bit(5, 1'b0, CYC + 3 * TICK);
        host.read_once();
        // spike gone before the check: channel back without a cycle
        sense[2].overload <= 1'b1;
        step(1);
        sense[2].overload <= 1'b0;
        wait_bit(2, 1'b0, 6);
        wait_bit(2, 1'b1, 2 * TICK + 4);
        // lasting overload with supply short
        sense[3] <= 6'h28;
        wait_bit(4, 1'b0, 3 * TICK);
        wait_bit(4, 1'b1, CYC + 3 * TICK);
        check(took > CYC - 3 * TICK, 1'b1, "cycle length");
        check(status.channel_on[3], 1'b0, "restart");
        sense[1].overload <= 1'b1;
        step(3 * TICK);
        check(status.cycle_done, 1'b1, "no rearm");
        check(report[3], 32'h0, "old data");
        host.read_once();
        step(1);
        check({report[3].permanent, report[3].short_vs}, 2'b11, "stored");
        sense <= '0;
        wait_bit(3, 1'b1, 2 * TICK + 4);
        // diagnostics off: only the faulty channel stays down
        host.write_ctrl(6'h20);
        sense[0].overload <= 1'b1;
        wait_bit(0, 1'b0, 6);
        step(5 * TICK);
        check(status.channel_on, 4'he, "only faulty off");
        sense[0].overload <= 1'b0;
        wait_bit(0, 1'b1, 2 * TICK + 4);
    endtask : scn_permanent

    // ch0 steady offset, ch1 offset with overload, ch2 offset starting late
    task automatic scn_offset();
        start(6'h30, '0);
        wait_bit(5, 1'b0, CYC + 3 * TICK);
        sense[0].offset_high <= 1'b1;
        sense[1].offset_high <= 1'b1;
        step(4);
        host.write_ctrl(6'h38);
        step(3);
        check(status.offset_active, 1'b1, "offset on");
        sense[1].overload <= 1'b1;
        sense[2].offset_high <= 1'b1;
        step(1);
        sense[1].overload <= 1'b0;
        step(30);
        host.read_once();
        step(1);
        check(report[0].offset, 1'b0, "not yet");
        host.read_once();
        step(1);
        check({report[3].offset, report[2].offset, report[1].offset, report[0].offset},
              4'h1, "offsets");
    endtask : scn_offset

    initial begin
        scn_turn_on();
        scn_permanent();
        scn_offset();
        complete_run();
    end
endmodule : tb_top
